// *** lpm_pkg.sv ***
// Package for the low-power mode controller: states and timing constants.
// Assumes a single 40 MHz clock with synchronous active-high reset.
package lpm_pkg;
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned CORE_DIV      = 6;
  localparam int unsigned DIV_W         = 3;
  localparam logic [DIV_W-1:0] DIV_LAST = 3'(CORE_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_HALF = 3'(CORE_DIV / 2);
  localparam logic [DIV_W-1:0] DIV_ZERO = 3'h0;
  // Inactivity time before sleep, in milliseconds
  localparam int unsigned IDLE_MS       = 1000;
  localparam int unsigned IDLE_CYCLES   = IDLE_MS * (CLK_HZ / 1000);
  localparam int unsigned IDLE_W        = 32;

  typedef enum logic [1:0] {
    LPM_RUN,
    LPM_SLEEP
  } lpm_mode_e;

  typedef enum logic [2:0] {
    LPM_SR_ACTIVE,
    LPM_SR_ENTER,
    LPM_SR_SELF,
    LPM_SR_EXIT,
    LPM_SR_XFER
  } lpm_sdram_e;
endpackage

// *** lpm_clk_if.sv ***
// Interface joining the mode controller to its clock divider/gate.
// Assumes both ends run on the same clk.
`timescale 1ns/100ps
interface lpm_clk_if;
  logic slow_req;
  logic gate_req;
  logic slow_act;
  logic gate_act;
  logic core_en;
  logic boundary;
  modport ctrl (output slow_req, output gate_req,
                input slow_act, input gate_act, input core_en,
                input boundary);
  modport gen  (input slow_req, input gate_req,
                output slow_act, output gate_act, output core_en,
                output boundary);
endinterface

// *** lpm_clkgen.sv ***
// Core clock enable divider and slot clock gate.
// Assumes downstream clock cells qualify clk with core_en and gate_act.
`timescale 1ns/100ps
module lpm_clkgen
  import lpm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Controller side
  lpm_clk_if.gen   cg
);
  logic [DIV_W-1:0] cnt;
  logic             slow;
  logic             gate;
  wire              at_wrap  = (cnt == DIV_LAST);
  wire              at_bound = !slow || at_wrap;

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt <= DIV_ZERO;
    end else if (at_wrap || !slow) begin
      cnt <= DIV_ZERO;
    end else begin
      cnt <= cnt + 3'h1;
    end
  end

  // Changes only at a divided-period end, no runt pulse
  always_ff @(posedge clk) begin
    if (srst) begin
      slow <= 1'b0;
      gate <= 1'b0;
    end else if (at_bound) begin
      slow <= cg.slow_req;
      gate <= cg.gate_req;
    end
  end

  // One enable in six while slow, every cycle otherwise
  assign cg.core_en  = !slow || (cnt == DIV_ZERO);
  assign cg.slow_act = slow;
  assign cg.gate_act = gate;
  assign cg.boundary = at_bound;
endmodule

// *** lpm_ctrl.sv ***
// Low-power mode controller: sleep entry, clock control, SDRAM self-refresh.
// Assumes inputs synchronous to clk and an SDRAM controller handshake.
`timescale 1ns/100ps
// Operation
// - In sleep, core clock runs at input divided by six; undivided after.
// - Slot clocks stop on sleep entry and stay stopped throughout.
// - Peripheral I/O controller clock keeps full rate in sleep.
// - Sleep entry with the enable set puts SDRAM in self-refresh, left for transactions, on wake or on enable cleared.
// - Pending transaction in self-refresh: exit first, then run it.
// - After serviced transaction, re-enter self-refresh if enable bit set.
// - Enter sleep after an inactivity period without activity.
// - Network requests are still answered while asleep.
// - Keyboard or pointer activity wakes the system from sleep.
module lpm_ctrl
  import lpm_pkg::*;
#(
  parameter int unsigned IDLE_COUNT = IDLE_CYCLES
)(
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Activity sources
  input  wire logic sys_activity,
  input  wire logic user_activity,
  input  wire logic net_request,
  // Software self-refresh enable
  input  wire logic sr_enable,
  // Memory transaction handshake
  input  wire logic mem_req,
  input  wire logic mem_done,
  output logic      mem_grant,
  // SDRAM self-refresh control
  output logic      sr_enter,
  output logic      sr_exit,
  input  wire logic sr_ack,
  output logic      sdram_in_sr,
  // Clock controls
  output logic      core_clk_en,
  output logic      slot_clk_en,
  output logic      pio_clk_en,
  output logic      sleep_active,
  output logic      net_serve
);
  lpm_clk_if cg ();

  lpm_clkgen u_clkgen (
    .clk  (clk),
    .srst (srst),
    .cg   (cg)
  );

  lpm_mode_e         mode;
  lpm_mode_e         next_mode;
  lpm_sdram_e        sst;
  lpm_sdram_e        next_sst;
  logic [IDLE_W-1:0] idle;
  logic [IDLE_W-1:0] next_idle;
  logic              next_enter;
  logic              next_exit;
  logic              next_in_sr;

  localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(IDLE_COUNT - 1);
  localparam logic [IDLE_W-1:0] IDLE_ZERO = '0;
  localparam logic [IDLE_W-1:0] IDLE_STEP = IDLE_W'(1);

  // Mode and SDRAM state decode
  wire asleep    = (mode == LPM_SLEEP);
  wire awake     = (mode == LPM_RUN);
  wire st_active = (sst == LPM_SR_ACTIVE);
  wire st_xfer   = (sst == LPM_SR_XFER);

  // Memory traffic restarts the timer; network requests never do
  wire any_act   = sys_activity || user_activity || mem_req;
  wire idle_done = (idle == IDLE_LAST);
  wire idle_hold = any_act || asleep;
  wire go_sleep  = awake && idle_done && !any_act;
  wire wake      = asleep && user_activity;

  // Self-refresh is wanted only while asleep with the enable set
  wire sr_wanted = asleep && sr_enable;
  // A granted transfer may still hold mem_req on its last cycle
  wire xfer_end  = !mem_req || mem_done;
  wire sr_go_in  = sr_wanted && xfer_end;
  wire sr_go_out = mem_req || !sr_wanted;

  // Inactivity timer; holds at its end point, no wrap
  always_comb begin
    next_idle = idle;
    if (idle_hold) begin
      next_idle = IDLE_ZERO;
    end else if (!idle_done) begin
      next_idle = idle + IDLE_STEP;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      idle <= IDLE_ZERO;
    end else begin
      idle <= next_idle;
    end
  end

  // Only user input wakes; network traffic is served while asleep
  always_comb begin
    next_mode = mode;
    case (mode)
      LPM_RUN: begin
        if (go_sleep) begin
          next_mode = LPM_SLEEP;
        end
      end
      LPM_SLEEP: begin
        if (wake) begin
          next_mode = LPM_RUN;
        end
      end
      default: begin
        next_mode = LPM_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode <= LPM_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  // SDRAM self-refresh sequencer
  always_comb begin
    next_sst = sst;
    case (sst)
      LPM_SR_ACTIVE: begin
        // Enter on sleep entry, never mid-transfer
        if (sr_go_in) begin
          next_sst = LPM_SR_ENTER;
        end
      end
      LPM_SR_ENTER: begin
        if (sr_ack) begin
          next_sst = LPM_SR_SELF;
        end
      end
      LPM_SR_SELF: begin
        // Exit before a transaction, on wake or on enable cleared
        if (sr_go_out) begin
          next_sst = LPM_SR_EXIT;
        end
      end
      LPM_SR_EXIT: begin
        // A pending transfer runs only once the exit is acknowledged
        if (sr_ack && mem_req) begin
          next_sst = LPM_SR_XFER;
        end else if (sr_ack) begin
          next_sst = LPM_SR_ACTIVE;
        end
      end
      LPM_SR_XFER: begin
        // Back to self-refresh only while enable still set
        if (mem_done && sr_wanted) begin
          next_sst = LPM_SR_ENTER;
        end else if (mem_done) begin
          next_sst = LPM_SR_ACTIVE;
        end
      end
      default: begin
        next_sst = LPM_SR_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sst <= LPM_SR_ACTIVE;
    end else begin
      sst <= next_sst;
    end
  end

  // Commands are registered so the SDRAM sees clean levels
  assign next_enter = (next_sst == LPM_SR_ENTER);
  assign next_exit  = (next_sst == LPM_SR_EXIT);
  assign next_in_sr = (next_sst == LPM_SR_SELF);

  always_ff @(posedge clk) begin
    if (srst) begin
      sr_enter <= 1'b0;
    end else begin
      sr_enter <= next_enter;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sr_exit <= 1'b0;
    end else begin
      sr_exit <= next_exit;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sdram_in_sr <= 1'b0;
    end else begin
      sdram_in_sr <= next_in_sr;
    end
  end

  // Grant blocked while SDRAM is in or moving through self-refresh
  assign mem_grant = mem_req && (st_active || st_xfer);

  // Requests to divide and gate; the divider applies them at a boundary
  assign cg.slow_req = asleep;
  assign cg.gate_req = asleep;

  assign core_clk_en  = cg.core_en;
  assign slot_clk_en  = !cg.gate_act;
  assign pio_clk_en   = 1'b1;
  assign sleep_active = asleep;
  // Passed straight through so sleep adds no latency to the network
  assign net_serve    = net_request;
endmodule

// *** lpm_ctrl_monitor.sv ***
// Port checker for the low-power mode controller.
// Assumes one clk domain, synchronous active-high srst.
`timescale 1ns/100ps
module lpm_ctrl_monitor #(
  parameter int unsigned IDLE_COUNT = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Inputs of the block
  input wire logic sys_activity,
  input wire logic user_activity,
  input wire logic net_request,
  input wire logic sr_enable,
  input wire logic mem_req,
  input wire logic mem_done,
  input wire logic sr_ack,
  // Outputs of the block
  input wire logic mem_grant,
  input wire logic sr_enter,
  input wire logic sr_exit,
  input wire logic sdram_in_sr,
  input wire logic core_clk_en,
  input wire logic slot_clk_en,
  input wire logic pio_clk_en,
  input wire logic sleep_active,
  input wire logic net_serve
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence slow_gap; !core_clk_en [*5]; endsequence
  sequence asleep; sleep_active [*8]; endsequence
  div_six_a: assert property (slow_gap |=> core_clk_en)
    else $error("core gap");
  slot_gate_a: assert property (asleep |-> !slot_clk_en)
    else $error("slot on");
  pio_run_a: assert property (pio_clk_en)
    else $error("pio off");
  sr_entry_a: assert property ($rose(sleep_active) && sr_enable
    && !mem_req |-> ##[0:1] sr_enter) else $error("no sr entry");
  idle_entry_a: assert property ($rose(sleep_active)
    |-> !$past(sys_activity) && !$past(user_activity) && !$past(mem_req))
    else $error("sleep on activity");
  gate_bound_a: assert property ($changed(slot_clk_en)
    |-> core_clk_en) else $error("gate mid period");
  exit_first_a: assert property (sdram_in_sr && mem_req
    |=> sr_exit && !mem_grant) else $error("no sr exit");
  re_enter_a: assert property (mem_grant && mem_done && sr_enable
    && sleep_active |=> sr_enter) else $error("no re-entry");
  wake_up_a: assert property (user_activity |=> !sleep_active)
    else $error("no wake");
  net_copy_a: assert property (net_serve == net_request)
    else $error("net lost");
endmodule

bind lpm_ctrl lpm_ctrl_monitor #(.IDLE_COUNT(IDLE_COUNT)) mon_i (.*);

// *** lpm_sdram_model.sv ***
// SDRAM stand-in acknowledging self-refresh entry and exit.
// Assumes commands are levels held until acknowledged.
`timescale 1ns/100ps
module lpm_sdram_model #(
  parameter int LAT = 2
) (
  // Clock
  input wire logic clk,
  // Commands from the block
  input wire logic sr_enter,
  input wire logic sr_exit,
  // Acknowledge back
  output logic     sr_ack
);
  int n = 0;
  initial sr_ack = 1'b0;
  // Ack is one pulse; a command still held is acked again every LAT+2 cycles
  always @(posedge clk) begin
    n <= ((sr_enter || sr_exit) && !sr_ack && n != LAT) ? n + 1 : 0;
    sr_ack <= (sr_enter || sr_exit) && !sr_ack && n == LAT;
  end
endmodule

// *** test_lpm_ctrl.sv ***
// Testbench for the low-power mode controller.
// Assumes IDLE_COUNT shortened to 16 cycles.
`timescale 1ns/100ps
module test_lpm_ctrl;
  import lpm_pkg::*;
  logic clk = 0, srst = 1, sys_activity = 0, user_activity = 0;
  logic net_request = 0, sr_enable = 1, mem_req = 0, mem_done = 0;
  logic mem_grant, sr_enter, sr_exit, sr_ack, sdram_in_sr;
  logic core_clk_en, slot_clk_en, pio_clk_en, sleep_active, net_serve;
  int n_errors = 0, compares = 0, k, c;
  lpm_ctrl #(.IDLE_COUNT(16)) lpm_ctrl_i (.*);
  lpm_sdram_model lpm_sdram_model_i (.*);
  initial forever #12.5 clk = ~clk;
  task results;
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task ck(input logic g, e, input string s);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %b seen %b", s, e, g);
    end
  endtask
  function automatic logic pick(input int i);
    case (i)
      0: return sleep_active;
      1: return sdram_in_sr;
      default: return mem_grant;
    endcase
  endfunction
  task wt(input int i, input logic v, input string s);
    for (k = 0; k < 60 && pick(i) !== v; k++) @(negedge clk);
    ck(pick(i), v, s);
    if (pick(i) !== v) results();
  endtask
  task t_idle;
    sys_activity = 1;
    repeat (30) @(negedge clk);
    sys_activity = 0;
    repeat (15) @(negedge clk);
    ck(sleep_active, 0, "sleep_active");
    @(negedge clk);
    ck(sleep_active, 1, "sleep_active");
  endtask
  task t_sleep;
    repeat (8) @(negedge clk);
    c = 0;
    repeat (12) begin
      @(negedge clk);
      if (core_clk_en === 1'b1) c++;
    end
    ck(c == 2, 1, "core pulses");
    ck(slot_clk_en, 0, "slot_clk_en");
    ck(pio_clk_en, 1, "pio_clk_en");
    net_request = 1;
    @(negedge clk);
    ck(net_serve, 1, "net_serve");
    net_request = 0;
    ck(sleep_active, 1, "sleep_active");
    wt(1, 1, "sdram_in_sr");
  endtask
  task t_mem;
    mem_req = 1;
    @(negedge clk);
    ck(mem_grant, 0, "mem_grant");
    ck(sr_exit, 1, "sr_exit");
    wt(2, 1, "mem_grant");
    ck(sdram_in_sr, 0, "sdram_in_sr");
    mem_done = 1;
    @(negedge clk);
    ck(sr_enter, 1, "sr_enter");
    mem_req = 0;
    mem_done = 0;
    wt(1, 1, "sdram_in_sr");
    sr_enable = 0;
    wt(1, 0, "sdram_in_sr");
    repeat (10) @(negedge clk);
    ck(sdram_in_sr, 0, "sdram_in_sr");
  endtask
  task t_wake;
    user_activity = 1;
    @(negedge clk);
    user_activity = 0;
    @(negedge clk);
    ck(sleep_active, 0, "sleep_active");
    repeat (8) @(negedge clk);
    ck(core_clk_en & slot_clk_en, 1, "clk enables");
  endtask
  initial begin
    repeat (3) @(negedge clk);
    srst = 0;
    t_idle();
    t_sleep();
    t_mem();
    t_wake();
    results();
  end
endmodule
